// file: rtl/dscc_pkg.sv
// Package for the drive serial configuration and cloning bank.
// Assumes a single 125 MHz clock and a parameter-index register port.
package dscc_pkg;

  // ----------------------------------------------------------------
  // Parameter indices (menu 11 numbering kept as index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PWRUP_DISP  = 8'h16;
  localparam logic [7:0] IDX_UNIT_ADDR   = 8'h17;
  localparam logic [7:0] IDX_PROTOCOL    = 8'h18;
  localparam logic [7:0] IDX_RATE        = 8'h19;
  localparam logic [7:0] IDX_TURN_DELAY  = 8'h1A;
  localparam logic [7:0] IDX_FW_VER      = 8'h1D;
  localparam logic [7:0] IDX_LOCK_CODE   = 8'h1E;
  localparam logic [7:0] IDX_RATED_CUR   = 8'h20;
  localparam logic [7:0] IDX_RATED_VOLT  = 8'h21;
  localparam logic [7:0] IDX_FW_SUBVER   = 8'h22;
  localparam logic [7:0] IDX_DSP_VER     = 8'h23;
  localparam logic [7:0] IDX_DISP_TMO    = 8'h29;
  localparam logic [7:0] IDX_CLONE       = 8'h2A;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_UNIT_ADDR  = 16'h000B; // 1.1 as group*10+unit
  localparam logic [15:0] RST_RATE       = 16'h0001;
  localparam logic [15:0] RST_TURN_DELAY = 16'h0014; // 20 ms
  localparam logic [15:0] RST_DISP_TMO   = 16'h00F0; // 240 s
  localparam logic [15:0] MAX_UNIT_ADDR  = 16'h00F7; // 24.7
  localparam logic [15:0] MAX_DELAY      = 16'h00FA; // 250
  localparam logic [15:0] MAX_LOCK       = 16'h270F; // 9999
  localparam logic [15:0] MAX_CLONE      = 16'h0004;
  localparam logic [15:0] MAX_PROTOCOL   = 16'h0002;
  localparam logic [15:0] MAX_RATE       = 16'h0003;
  localparam logic [15:0] FBUS_ADDR      = 16'h000B; // fixed 11
  localparam logic [1:0]  FBUS_RATE      = 2'h3;     // 19.2 kbaud
  // Unit address is held as group*10+unit; the unit digit runs 0..7
  localparam logic [15:0] ADDR_RADIX     = 16'h000A;
  localparam logic [15:0] ADDR_UNIT_MAX  = 16'h0007;

  // Protocol and clone codes
  localparam logic [1:0]  PROTO_ANSI     = 2'h0;
  localparam logic [1:0]  PROTO_RTU      = 2'h1;
  localparam logic [1:0]  PROTO_FBUS     = 2'h2;
  localparam logic [2:0]  CLONE_NONE     = 3'h0;
  localparam logic [2:0]  CLONE_READ     = 3'h1;
  localparam logic [2:0]  CLONE_PROG     = 3'h2;
  localparam logic [2:0]  CLONE_AUTO     = 3'h3;
  localparam logic [2:0]  CLONE_BOOT     = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 125;
  localparam int MS_CYCLES     = CLK_MHZ * 1000;
  localparam int HOLD_US       = 1500;          // driver hold 1.5 ms
  localparam int HOLD_CYCLES   = (HOLD_US * CLK_MHZ) - 1; // longest: floor
  localparam int SEC_MS        = 1000;
  localparam int US_PER_MS     = 1000;

endpackage

// file: rtl/dscc_tick.sv
// Time-base divider: pulse lasting one enabled cycle, every DIV enabled cycles.
// Assumes a synchronous active-low reset and a clock enable.
`timescale 1ns/1ns
`default_nettype none
module dscc_tick #(
  parameter int DIV = 125000
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  // Tick
  output logic      tick_o
);
  logic [31:0] cnt_r;

  // Free-running divider; the tick is a registered pulse
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (cnt_r == 32'(DIV - 1)) begin
        cnt_r  <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + 32'h0000_0001;
        tick_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/dscc_turn.sv
// Half-duplex line turnaround: reply delay then driver hold.
// Assumes ms_tick_i is a one-cycle pulse each millisecond.
`timescale 1ns/1ns
`default_nettype none
module dscc_turn
  import dscc_pkg::*;
#(
  // Hold length in cycles; follows the ms divider of the bank
  parameter int HOLD_LEN = HOLD_CYCLES + 1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic        ms_tick_i,
  // Control
  input  wire logic        ansi_i,
  input  wire logic [7:0]  delay_ms_i,
  input  wire logic        host_msg_end_i,
  input  wire logic        tx_last_done_i,
  // Status
  output logic             tx_enable_o,
  output logic             tx_ready_o
);
  typedef enum logic [1:0] {
    DSCC_IDLE = 2'b00,
    DSCC_WAIT = 2'b01,
    DSCC_SEND = 2'b11,
    DSCC_HOLD = 2'b10
  } dscc_turn_e;

  dscc_turn_e  st_r;
  logic [7:0]  ms_r;
  logic [31:0] hold_r;

  // Reply wait counted in whole ms ticks, so the wait is never short;
  // drivers stay on for the hold period after the last character
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r        <= DSCC_IDLE;
      ms_r        <= '0;
      hold_r      <= '0;
      tx_enable_o <= 1'b0;
      tx_ready_o  <= 1'b0;
    end else if (ce_i) begin
      unique case (st_r)
        DSCC_IDLE: begin
          if (host_msg_end_i) begin
            ms_r <= '0;
            st_r <= DSCC_WAIT;
          end
        end
        DSCC_WAIT: begin
          // ANSI waits the programmed delay, others reply at once
          if (!ansi_i || ms_r > delay_ms_i) begin
            st_r        <= DSCC_SEND;
            tx_enable_o <= 1'b1;
            tx_ready_o  <= 1'b1;
          end else if (ms_tick_i) begin
            ms_r <= ms_r + 8'h01;
          end
        end
        DSCC_SEND: begin
          if (tx_last_done_i) begin
            hold_r     <= '0;
            tx_ready_o <= 1'b0;
            st_r       <= DSCC_HOLD;
          end
        end
        DSCC_HOLD: begin
          if (hold_r == 32'(HOLD_LEN - 1)) begin
            tx_enable_o <= 1'b0;
            st_r        <= DSCC_IDLE;
          end else begin
            hold_r <= hold_r + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  hold_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(tx_enable_o) |-> $past(st_r) == DSCC_HOLD)
    else $error("drivers released outside hold");
  wait_ansi_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(tx_ready_o) && ansi_i |-> ms_r > delay_ms_i)
    else $error("reply before programmed delay");
endmodule
`default_nettype wire

// file: rtl/dscc_bank.sv
// Miscellaneous settings bank: serial link, display, lock, cloning.
// Assumes a parameter-index write/read port as the drive's own access
// path, plus keypad, reset and non-volatile store handshakes.
//
// Notes on behaviour
// - Address group.unit, 0.0 to 24.7
// - Protocol code picks ANSI, RTU or fieldbus
// - Fieldbus forces address 11, 19.2 kbaud
// - Fieldbus exposes two extra level-two settings
// - Rate codes 2400/4800/9600/19200; default 4800
// - ANSI reply waits programmed delay, default 20
// - Drivers held up to 1.5 ms after reply
// - Power-up display: 0 speed, 1 load
// - Keypad toggle updates selector and saves it
// - Serial write of selector is not saved
// - Nonzero lock code blocks basic-set changes
// - Keypad idle timeout reverts display, default 240
// - Clone 2: keypad reset stores unit to key
// - After a clone 2 key store, clone selector returns 0
// - Clone 3: every save also updates key
`timescale 1ns/1ns
`default_nettype none
module dscc_bank
  import dscc_pkg::*;
#(
  parameter logic [15:0] FW_VERSION  = 16'h0064, // arbitrary value
  parameter logic [15:0] FW_SUBVER   = 16'h0000, // arbitrary value
  parameter logic [15:0] DSP_VERSION = 16'h000A, // arbitrary value
  parameter logic [15:0] RATED_CUR   = 16'h0096, // arbitrary value
  parameter logic [15:0] RATED_VOLT  = 16'h00F0, // arbitrary value
  parameter int          MS_DIV      = MS_CYCLES,
  parameter int          SEC_DIV     = SEC_MS
) (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  // Parameter access port
  input  wire logic        par_wr_i,
  input  wire logic        par_serial_i,
  input  wire logic        par_basic_i,
  input  wire logic [7:0]  par_idx_i,
  input  wire logic [15:0] par_wdata_i,
  output logic [15:0]      par_rdata_o,
  output logic             par_refused_o,
  // Serial line turnaround
  input  wire logic        host_msg_end_i,
  input  wire logic        tx_last_done_i,
  output logic             tx_enable_o,
  output logic             tx_ready_o,
  output logic [15:0]      link_addr_o,
  output logic [1:0]       link_rate_o,
  output logic [1:0]       link_proto_o,
  output logic             fbus_extra_vis_o,
  // Keypad and display
  input  wire logic        key_activity_i,
  input  wire logic        key_toggle_load_i,
  input  wire logic        param_mode_i,
  output logic             disp_revert_o,
  output logic             disp_load_o,
  // Drive state and resets
  input  wire logic        power_up_i,
  input  wire logic        unit_reset_i,
  input  wire logic        keypad_reset_i,
  input  wire logic        inhibited_state_i,
  input  wire logic        tripped_state_i,
  input  wire logic        standby_state_i,
  input  wire logic        nv_saved_i,
  // Non-volatile and key requests
  output logic             nv_save_req_o,
  output logic             key_store_req_o,
  output logic             key_load_req_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic        pwrup_disp_r;
  logic [15:0] unit_addr_r;
  logic [1:0]  protocol_r;
  logic [1:0]  rate_r;
  logic [7:0]  turn_delay_r;
  logic [15:0] lock_code_r;
  logic [7:0]  disp_tmo_r;
  logic [2:0]  clone_r;
  logic        ms_tick;
  logic        sec_tick;
  logic        sec_pulse;
  logic [7:0]  idle_sec_r;
  logic        wr_ok;
  logic        wr_nxt;
  logic        idle_drive;
  logic        tx_en;
  logic        tx_rdy;

  // Lock applies to basic-set writes only
  assign wr_ok  = par_wr_i && !(par_basic_i && lock_code_r != '0);
  assign wr_nxt = wr_ok;
  assign idle_drive = inhibited_state_i || tripped_state_i ||
                      standby_state_i;
  // Seconds divider steps on ms ticks, so its output stands a whole ms;
  // gating with the ms tick leaves one cycle per second
  assign sec_pulse = sec_tick && ms_tick;

  // ----------------------------------------------------------------
  // Time bases
  // ----------------------------------------------------------------
  dscc_tick #(.DIV(MS_DIV)) u_ms (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .tick_o    (ms_tick)
  );

  dscc_tick #(.DIV(SEC_DIV)) u_sec (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i && ms_tick),
    .tick_o    (sec_tick)
  );

  dscc_turn #(.HOLD_LEN((MS_DIV * HOLD_US) / US_PER_MS)) u_turn (
    .clk_i          (clk_i),
    .reset_n_i      (reset_n_i),
    .ce_i           (ce_i),
    .ms_tick_i      (ms_tick),
    .ansi_i         (protocol_r == PROTO_ANSI),
    .delay_ms_i     (turn_delay_r),
    .host_msg_end_i (host_msg_end_i),
    .tx_last_done_i (tx_last_done_i),
    .tx_enable_o    (tx_en),
    .tx_ready_o     (tx_rdy)
  );

  // ----------------------------------------------------------------
  // Link settings
  // ----------------------------------------------------------------
  // Out-of-range writes are dropped so stored codes stay legal
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      unit_addr_r  <= RST_UNIT_ADDR;
      protocol_r   <= PROTO_ANSI;
      rate_r       <= RST_RATE[1:0];
      turn_delay_r <= RST_TURN_DELAY[7:0];
    end else if (ce_i && wr_nxt) begin
      if (par_idx_i == IDX_UNIT_ADDR && par_wdata_i <= MAX_UNIT_ADDR &&
          (par_wdata_i % ADDR_RADIX) <= ADDR_UNIT_MAX) begin
        unit_addr_r <= par_wdata_i;
      end
      if (par_idx_i == IDX_PROTOCOL && par_wdata_i <= MAX_PROTOCOL) begin
        protocol_r <= par_wdata_i[1:0];
      end
      if (par_idx_i == IDX_RATE && par_wdata_i <= MAX_RATE) begin
        rate_r <= par_wdata_i[1:0];
      end
      if (par_idx_i == IDX_TURN_DELAY && par_wdata_i <= MAX_DELAY) begin
        turn_delay_r <= par_wdata_i[7:0];
      end
    end
  end

  // Effective link setup; fieldbus overrides stored values
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      link_addr_o      <= RST_UNIT_ADDR;
      link_rate_o      <= RST_RATE[1:0];
      link_proto_o     <= PROTO_ANSI;
      fbus_extra_vis_o <= 1'b0;
      tx_enable_o      <= 1'b0;
      tx_ready_o       <= 1'b0;
    end else if (ce_i) begin
      link_proto_o     <= protocol_r;
      fbus_extra_vis_o <= (protocol_r == PROTO_FBUS);
      link_addr_o      <= (protocol_r == PROTO_FBUS) ? FBUS_ADDR
                                                     : unit_addr_r;
      link_rate_o      <= (protocol_r == PROTO_FBUS) ? FBUS_RATE
                                                     : rate_r;
      tx_enable_o      <= tx_en;
      tx_ready_o       <= tx_rdy;
    end
  end

  // ----------------------------------------------------------------
  // Display, lock, timeout
  // ----------------------------------------------------------------
  // Keypad toggle wins over a same-cycle serial write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pwrup_disp_r <= 1'b0;
      lock_code_r  <= '0;
      disp_tmo_r   <= RST_DISP_TMO[7:0];
    end else if (ce_i) begin
      if (key_toggle_load_i) begin
        pwrup_disp_r <= ~pwrup_disp_r;
      end else if (wr_nxt && par_idx_i == IDX_PWRUP_DISP) begin
        pwrup_disp_r <= par_wdata_i[0];
      end
      if (wr_nxt && par_idx_i == IDX_LOCK_CODE && par_wdata_i <= MAX_LOCK) begin
        lock_code_r <= par_wdata_i;
      end
      if (wr_nxt && par_idx_i == IDX_DISP_TMO && par_wdata_i <= MAX_DELAY) begin
        disp_tmo_r <= par_wdata_i[7:0];
      end
    end
  end

  // Idle seconds in whole ticks, so the revert is never early;
  // zero timeout means revert never fires
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      idle_sec_r    <= '0;
      disp_revert_o <= 1'b0;
      disp_load_o   <= 1'b0;
    end else if (ce_i) begin
      disp_load_o   <= pwrup_disp_r;
      disp_revert_o <= 1'b0;
      if (key_activity_i || !param_mode_i) begin
        idle_sec_r <= '0;
      end else if (sec_pulse && disp_tmo_r != '0) begin
        if (idle_sec_r >= disp_tmo_r) begin
          disp_revert_o <= 1'b1;
          idle_sec_r    <= '0;
        end else begin
          idle_sec_r <= idle_sec_r + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Cloning
  // ----------------------------------------------------------------
  // Requests are one-cycle pulses; the clone 2 key store also clears the code
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      clone_r         <= CLONE_NONE;
      key_store_req_o <= 1'b0;
      key_load_req_o  <= 1'b0;
      nv_save_req_o   <= 1'b0;
    end else if (ce_i) begin
      key_store_req_o <= 1'b0;
      key_load_req_o  <= 1'b0;
      nv_save_req_o   <= key_toggle_load_i;
      if (clone_r == CLONE_PROG && (keypad_reset_i || unit_reset_i)) begin
        key_store_req_o <= 1'b1;
        clone_r         <= CLONE_NONE;
      end else if (clone_r == CLONE_READ && unit_reset_i && idle_drive) begin
        key_load_req_o <= 1'b1;
        nv_save_req_o  <= 1'b1;
      end else if (clone_r == CLONE_BOOT && power_up_i) begin
        key_load_req_o <= 1'b1;
        nv_save_req_o  <= 1'b1;
      end else if (clone_r == CLONE_AUTO && nv_saved_i) begin
        key_store_req_o <= 1'b1;
      end else if (wr_nxt && par_idx_i == IDX_CLONE &&
                   par_wdata_i <= MAX_CLONE) begin
        clone_r <= par_wdata_i[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path and refusal flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      par_rdata_o   <= '0;
      par_refused_o <= 1'b0;
    end else if (ce_i) begin
      par_refused_o <= par_wr_i && !wr_ok;
      unique case (par_idx_i)
        IDX_PWRUP_DISP: par_rdata_o <= {15'h0000, pwrup_disp_r};
        IDX_UNIT_ADDR:  par_rdata_o <= unit_addr_r;
        IDX_PROTOCOL:   par_rdata_o <= {14'h0000, protocol_r};
        IDX_RATE:       par_rdata_o <= {14'h0000, rate_r};
        IDX_TURN_DELAY: par_rdata_o <= {8'h00, turn_delay_r};
        IDX_FW_VER:     par_rdata_o <= FW_VERSION;
        IDX_LOCK_CODE:  par_rdata_o <= lock_code_r;
        IDX_RATED_CUR:  par_rdata_o <= RATED_CUR;
        IDX_RATED_VOLT: par_rdata_o <= RATED_VOLT;
        IDX_FW_SUBVER:  par_rdata_o <= FW_SUBVER;
        IDX_DSP_VER:    par_rdata_o <= DSP_VERSION;
        IDX_DISP_TMO:   par_rdata_o <= {8'h00, disp_tmo_r};
        IDX_CLONE:      par_rdata_o <= {13'h0000, clone_r};
        default:        par_rdata_o <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fbus_addr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && protocol_r == PROTO_FBUS |=> link_addr_o == FBUS_ADDR)
    else $error("fieldbus address not forced");
  fbus_vis_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i |=> fbus_extra_vis_o == ($past(protocol_r) == PROTO_FBUS))
    else $error("extra settings visibility wrong");
  lock_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && par_wr_i && par_basic_i && lock_code_r != '0
    |=> par_refused_o)
    else $error("locked write not refused");
  store_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(key_store_req_o) && $past(clone_r) == CLONE_PROG
    |-> clone_r == CLONE_NONE)
    else $error("clone code not cleared");
  serial_nosave_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && par_wr_i && par_idx_i == IDX_PWRUP_DISP && !key_toggle_load_i
    && clone_r != CLONE_READ && clone_r != CLONE_BOOT
    |=> !nv_save_req_o)
    else $error("serial selector write saved");
  read_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && clone_r == CLONE_READ && unit_reset_i && idle_drive
    |=> key_load_req_o && nv_save_req_o)
    else $error("key load missing");
  rate_ok_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rate_r <= MAX_RATE[1:0])
    else $error("rate code out of range");
  addr_ok_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    unit_addr_r <= MAX_UNIT_ADDR)
    else $error("unit address out of range");
endmodule
`default_nettype wire

// file: verification/dscc_host_model.sv
// Host side of the half-duplex link, seen by the settings bank.
// Assumes the bench raises start_i at a falling edge, one exchange a time.
`timescale 1ns/1ns
`default_nettype none
module dscc_host_model (
  // Clock and control
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic        tx_enable_i,
  input  wire logic        tx_ready_i,
  // Link strobes and observations
  output logic             host_msg_end_o,
  output logic             tx_last_done_o,
  output logic [15:0]      wait_o,
  output logic             held_o,
  output logic             done_o
);
  initial begin
    host_msg_end_o = 1'b0;
    tx_last_done_o = 1'b0;
    wait_o = 16'h0000;
    held_o = 1'b0;
    done_o = 1'b0;
  end
  // One exchange; the host never talks over the drive's hold time
  always @(posedge start_i) begin
    done_o = 1'b0;
    host_msg_end_o = 1'b1;
    @(negedge clk_i);
    host_msg_end_o = 1'b0;
    wait_o = 16'h0000;
    while (tx_ready_i !== 1'b1 && wait_o < 16'h07D0) begin
      @(negedge clk_i);
      wait_o = wait_o + 16'h0001;
    end
    repeat (3) @(negedge clk_i);
    tx_last_done_o = 1'b1;
    @(negedge clk_i);
    tx_last_done_o = 1'b0;
    held_o = tx_enable_i;
    // Wait out the driver hold before any new message, bounded
    repeat (400) if (tx_enable_i === 1'b1) @(negedge clk_i);
    done_o = 1'b1;
  end
endmodule
`default_nettype wire

// file: verification/tb_drive_serial_config_and_cloning.sv
// Self-checking bench for the settings bank with a host model.
// Assumes short time bases: 10 cycles a ms, 4 ms a second.
`timescale 1ns/1ns
`default_nettype none
module tb_drive_serial_config_and_cloning;
  import dscc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, basic = 1'b0, start = 1'b0;
  logic act = 1'b0, tog = 1'b0, pmode = 1'b0, pup = 1'b0, urst = 1'b0;
  logic krst = 1'b0, inh = 1'b0, saved = 1'b0, trp = 1'b0, ce = 1'b1;
  logic [7:0] idx = 8'h00;
  logic [15:0] wd = 16'h0000, rd, hwait, addr;
  logic [1:0] rate, proto;
  logic ref_p, msg_end, last_done, txe, txr, vis, rev, load, held, hdone;
  logic nvs, kst, kld;
  int fails = 0, checks = 0, cyc = 0, n_nv = 0, n_st = 0, n_ld = 0;
  int n_ref = 0, n_rev = 0;
  always #4 clk = ~clk;
  dscc_bank #(.MS_DIV(10), .SEC_DIV(4)) dut_u (.clk_i(clk),
    .reset_n_i(rst_n), .ce_i(ce), .par_wr_i(wr), .par_serial_i(1'b1),
    .par_basic_i(basic), .par_idx_i(idx), .par_wdata_i(wd),
    .par_rdata_o(rd), .par_refused_o(ref_p), .host_msg_end_i(msg_end),
    .tx_last_done_i(last_done), .tx_enable_o(txe), .tx_ready_o(txr),
    .link_addr_o(addr), .link_rate_o(rate), .link_proto_o(proto),
    .fbus_extra_vis_o(vis), .key_activity_i(act), .key_toggle_load_i(tog),
    .param_mode_i(pmode), .disp_revert_o(rev), .disp_load_o(load),
    .power_up_i(pup), .unit_reset_i(urst), .keypad_reset_i(krst),
    .inhibited_state_i(inh), .tripped_state_i(trp),
    .standby_state_i(1'b0), .nv_saved_i(saved), .nv_save_req_o(nvs),
    .key_store_req_o(kst), .key_load_req_o(kld));
  dscc_host_model host_u (.clk_i(clk), .start_i(start), .tx_enable_i(txe),
    .tx_ready_i(txr), .host_msg_end_o(msg_end), .tx_last_done_o(last_done),
    .wait_o(hwait), .held_o(held), .done_o(hdone));
  // Pulse counters, so one-cycle outputs are never missed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_nv <= n_nv + int'(nvs === 1'b1);
    n_st <= n_st + int'(kst === 1'b1);
    n_ld <= n_ld + int'(kld === 1'b1);
    n_ref <= n_ref + int'(ref_p === 1'b1);
    n_rev <= n_rev + int'(rev === 1'b1);
    if (cyc == 60000) begin
      fails = fails + 1;
      results();
    end
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrp(logic [7:0] i, logic [15:0] d, logic b);
    @(negedge clk);
    wr = 1'b1;
    idx = i;
    wd = d;
    basic = b;
    @(negedge clk);
    wr = 1'b0;
    basic = 1'b0;
    @(negedge clk);
  endtask
  task automatic rdc(string nm, logic [7:0] i, logic [15:0] e);
    @(negedge clk);
    idx = i;
    @(negedge clk);
    chk(nm, rd, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Reset values and the effective link settings
  task automatic t_reset();
    rdc("pwrup", IDX_PWRUP_DISP, 16'h0000);
    rdc("proto", IDX_PROTOCOL, 16'h0000);
    rdc("rate", IDX_RATE, 16'h0001);
    rdc("delay", IDX_TURN_DELAY, 16'h0014);
    rdc("lock", IDX_LOCK_CODE, 16'h0000);
    rdc("tmo", IDX_DISP_TMO, 16'h00F0);
    rdc("clone", IDX_CLONE, 16'h0000);
    chk("lrate", {14'h0, rate}, 16'h0001);
    rdc("addr0", IDX_UNIT_ADDR, RST_UNIT_ADDR);
    chk("laddr", addr, RST_UNIT_ADDR);
    // A write while the enable is low must not land
    ce = 1'b0;
    wrp(IDX_RATE, 16'h0003, 1'b0);
    ce = 1'b1;
    rdc("frozen", IDX_RATE, 16'h0001);
  endtask
  // Address limit, every rate and protocol code, fieldbus override
  task automatic t_link();
    wrp(IDX_UNIT_ADDR, 16'h00F7, 1'b0);
    wrp(IDX_UNIT_ADDR, 16'h00F8, 1'b0);
    wrp(IDX_UNIT_ADDR, 16'h0013, 1'b0);
    rdc("addr", IDX_UNIT_ADDR, 16'h00F7);
    for (int r = 0; r < 4; r++) begin
      wrp(IDX_RATE, 16'(r), 1'b0);
      chk("lrate", {14'h0, rate}, 16'(r));
    end
    for (int p = 0; p < 3; p++) begin
      wrp(IDX_PROTOCOL, 16'(p), 1'b0);
      chk("proto", {14'h0, proto}, 16'(p));
    end
    wrp(IDX_RATE, 16'h0000, 1'b0);
    chk("fb_addr", addr, 16'h000B);
    chk("fb_rate", {14'h0, rate}, 16'h0003);
    chk("fb_vis", {15'h0, vis}, 16'h0001);
    wrp(IDX_PROTOCOL, 16'h0000, 1'b0);
    chk("addr_o", addr, 16'h00F7);
    chk("vis0", {15'h0, vis}, 16'h0000);
  endtask
  // ANSI reply slot after a 2 ms delay, drivers held after the reply
  task automatic xchg();
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3000) if (hdone !== 1'b1) @(negedge clk);
  endtask
  task automatic t_turn();
    wrp(IDX_TURN_DELAY, 16'h0002, 1'b0);
    xchg();
    chk("slot", {15'h0, hwait >= 16'd20 && hwait <= 16'd35}, 16'h1);
    chk("held", {15'h0, held}, 16'h0001);
    chk("txe_off", {15'h0, txe}, 16'h0000);
    // RTU replies without the programmed delay
    wrp(IDX_PROTOCOL, 16'h0001, 1'b0);
    xchg();
    chk("rtu_slot", {15'h0, hwait < 16'd5}, 16'h1);
    chk("rtu_held", {15'h0, held}, 16'h0001);
    chk("rtu_off", {15'h0, txe}, 16'h0000);
    wrp(IDX_PROTOCOL, 16'h0000, 1'b0);
  endtask
  // Lock refuses basic writes; toggle saves, serial write does not
  task automatic t_lock_disp();
    int nv0;
    wrp(IDX_LOCK_CODE, 16'h0005, 1'b0);
    wrp(IDX_RATE, 16'h0002, 1'b1);
    chk("refused", 16'(n_ref), 16'h0001);
    rdc("rate_l", IDX_RATE, 16'h0000);
    wrp(IDX_LOCK_CODE, 16'h0000, 1'b0);
    nv0 = n_nv;
    pulse(tog);
    chk("load", {15'h0, load}, 16'h0001);
    chk("tog_sv", 16'(n_nv - nv0), 16'h0001);
    wrp(IDX_PWRUP_DISP, 16'h0000, 1'b0);
    chk("ser_sv", 16'(n_nv - nv0), 16'h0001);
    chk("load0", {15'h0, load}, 16'h0000);
  endtask
  // Each cloning code with its trigger
  task automatic t_clone();
    wrp(IDX_CLONE, 16'h0002, 1'b0);
    pulse(krst);
    chk("store", 16'(n_st), 16'h0001);
    rdc("clr", IDX_CLONE, 16'h0000);
    wrp(IDX_CLONE, 16'h0003, 1'b0);
    pulse(saved);
    chk("auto", 16'(n_st), 16'h0002);
    wrp(IDX_CLONE, 16'h0002, 1'b0);
    pulse(urst);
    chk("store_u", 16'(n_st), 16'h0003);
    wrp(IDX_CLONE, 16'h0001, 1'b0);
    pulse(urst);
    chk("no_idle", 16'(n_ld), 16'h0000);
    inh = 1'b1;
    pulse(urst);
    inh = 1'b0;
    chk("read", 16'(n_ld), 16'h0001);
    trp = 1'b1;
    pulse(urst);
    trp = 1'b0;
    chk("read_t", 16'(n_ld), 16'h0002);
    wrp(IDX_CLONE, 16'h0004, 1'b0);
    pulse(pup);
    chk("boot", 16'(n_ld), 16'h0003);
  endtask
  // One second is 40 cycles here; revert needs a full idle second
  task automatic t_tmo();
    int rv0;
    wrp(IDX_DISP_TMO, 16'h0001, 1'b0);
    pmode = 1'b1;
    repeat (38) @(negedge clk);
    chk("early", 16'(n_rev), 16'h0000);
    repeat (50) @(negedge clk);
    chk("revert", 16'(n_rev > 0), 16'h0001);
    act = 1'b1;
    rv0 = n_rev;
    repeat (100) @(negedge clk);
    chk("busy", 16'(n_rev - rv0), 16'h0000);
    act = 1'b0;
    pmode = 1'b0;
  endtask
  task automatic results();
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_link();
    t_turn();
    t_lock_disp();
    t_clone();
    t_tmo();
    results();
  end
endmodule
`default_nettype wire
